// [rtl/tcwm_counter16.sv]
// Our own choices: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module tcwm_counter16
  import tcwm_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [1:0]       waveform_pin_o,
  output logic [1:0]       waveform_pin_oe
);

  ////////////////////////////////////////////////////////////////////////////
  // declarations

  logic        awready_q, wready_q, bvalid_q, arready_q, rvalid_q; // bus handshake flops
  logic [1:0]  bresp_q, rresp_q;                    // bus responses
  logic [31:0] rdata_q;                             // read data
  logic        aw_have_q, w_have_q;                 // captured halves of a write
  logic [7:0]  aw_addr_q;                           // captured write address
  logic [31:0] w_data_q;                            // captured write data
  logic [3:0]  w_strb_q;                            // captured byte strobes
  logic        wr_do;                               // write performed this cycle
  logic [15:0] ctrl_q;                              // mode, actions, prescaler
  logic [15:0] count_q;                             // count_value
  logic [15:0] captop_q;                            // capture_top_value
  logic [3:0]  flags_q;                             // sticky flags
  logic [1:0]  pindir_q;                            // pin direction bits
  logic [15:0] cmp_q     [2];                       // active compare values
  logic [15:0] cmp_buf_q [2];                       // compare buffers
  logic [1:0]  wave_q;                              // internal waveform registers
  logic [1:0]  pin_o_q, pin_oe_q;                   // pin drive flops
  logic [10:0] psc_cnt_q;                           // prescaler counter
  logic        block_q;                             // count write blocks next match
  logic [3:0]  mode;                                // waveform_mode_select
  logic [2:0]  psc_sel;                             // prescaler select
  logic [1:0]  act [2];                             // output_action_select per channel
  logic [10:0] psc_div;                             // selected divisor
  logic        tick;                                // timer clock enable pulse
  logic        is_fpwm, is_ctc, fixed_top;          // mode classes
  logic        top_is_cmpa, top_is_cap;             // register that owns top
  logic [15:0] top;                                 // current top value
  logic [15:0] wmask;                               // compare write mask
  logic        at_top;                              // counter clears this tick
  logic        at_max;                              // counter wraps max to zero
  logic [1:0]  match;                               // compare match per channel
  logic        wr_ctrl, wr_count, wr_captop, wr_flags, wr_pindir;
  logic [1:0]  wr_cmp;                              // compare write per channel
  logic [15:0] wval_ctrl, wval_count, wval_captop;  // strobe-merged values
  logic [15:0] wval_cmp [2];                        // masked compare values

  // byte-strobe merge of a 16-bit register
  function automatic logic [15:0] merge16(input logic [15:0] old_v,
                                          input logic [31:0] new_v,
                                          input logic [3:0]  strb);
    merge16 = {strb[1] ? new_v[15:8] : old_v[15:8],
               strb[0] ? new_v[7:0]  : old_v[7:0]};
  endfunction

  // word-aligned address compare
  function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
    hit = (a[7:2] == r[7:2]);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // mode decode and top selection

  assign mode    = ctrl_q[CTRL_MODE_LSB +: 4];
  assign psc_sel = ctrl_q[CTRL_PSC_LSB +: 3];
  assign act[0]  = ctrl_q[CTRL_ACTA_LSB +: 2];
  assign act[1]  = ctrl_q[CTRL_ACTB_LSB +: 2];

  // modes outside this set (dual slope) fall back to the normal sequence
  always_comb begin
    is_fpwm     = 1'b0;
    is_ctc      = 1'b0;
    fixed_top   = 1'b0;
    top_is_cmpa = 1'b0;
    top_is_cap  = 1'b0;
    top         = CNT_MAX;
    unique case (mode)
      MODE_CTC_CMPA: begin
        is_ctc      = 1'b1;
        top_is_cmpa = 1'b1;
        top         = cmp_q[0];
      end
      MODE_CTC_CAP: begin
        is_ctc     = 1'b1;
        top_is_cap = 1'b1;
        top        = captop_q;
      end
      MODE_FPWM8: begin
        is_fpwm   = 1'b1;
        fixed_top = 1'b1;
        top       = TOP_8BIT;
      end
      MODE_FPWM9: begin
        is_fpwm   = 1'b1;
        fixed_top = 1'b1;
        top       = TOP_9BIT;
      end
      MODE_FPWM10: begin
        is_fpwm   = 1'b1;
        fixed_top = 1'b1;
        top       = TOP_10BIT;
      end
      MODE_FPWM_CAP: begin
        is_fpwm    = 1'b1;
        top_is_cap = 1'b1;
        top        = captop_q;
      end
      MODE_FPWM_CMP: begin
        is_fpwm     = 1'b1;
        top_is_cmpa = 1'b1;
        top         = cmp_q[0];
      end
      default: begin
        top = CNT_MAX;
      end
    endcase
  end

  // fixed tops are all-ones masks of their resolution
  assign wmask = fixed_top ? top : CNT_MAX;

  ////////////////////////////////////////////////////////////////////////////
  // prescaler: one tick every N clocks, none when stopped

  always_comb begin
    unique case (psc_sel)
      PSC_1:   psc_div = DIV_1;
      PSC_8:   psc_div = DIV_8;
      PSC_64:  psc_div = DIV_64;
      PSC_256: psc_div = DIV_256;
      default: psc_div = DIV_1024;
    endcase
  end

  assign tick = (psc_sel != PSC_STOP) && (psc_cnt_q == psc_div - 11'h001);

  // prescaler counter restarts on each tick and while stopped
  always_ff @(posedge aclk) begin
    if (!aresetn || tick || psc_sel == PSC_STOP) begin
      psc_cnt_q <= 11'h000;
    end else begin
      psc_cnt_q <= psc_cnt_q + 11'h001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // match detection

  // a top match is a compare match, so a count write blocks it too
  assign at_top = tick && !block_q && (is_fpwm || is_ctc) && (count_q == top);
  assign at_max = tick && (count_q == CNT_MAX);

  // blocking lasts until the next timer tick after a count write
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      block_q <= 1'b0;
    end else if (wr_count) begin
      block_q <= 1'b1;
    end else if (tick) begin
      block_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // counter: the sequence depends on the mode and its top value, never on actions

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_q <= CNT_BOTTOM;
    end else if (wr_count) begin
      count_q <= wval_count;
    end else if (at_top) begin
      count_q <= CNT_BOTTOM;
    end else if (tick) begin
      // a top written below the count is missed: run on to max and wrap
      count_q <= count_q + 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // flags: hardware sets, software writes one to clear, set wins

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flags_q <= 4'h0;
    end else begin
      // overflow: at max wrap outside fast PWM, at top inside it
      if ((!is_fpwm && at_max) || (is_fpwm && at_top)) begin
        flags_q[FLG_OVF] <= 1'b1;
      end else if (wr_flags && w_strb_q[0] && w_data_q[FLG_OVF]) begin
        flags_q[FLG_OVF] <= 1'b0;
      end
      if (match[0]) begin
        flags_q[FLG_CMPA] <= 1'b1;
      end else if (wr_flags && w_strb_q[0] && w_data_q[FLG_CMPA]) begin
        flags_q[FLG_CMPA] <= 1'b0;
      end
      if (match[1]) begin
        flags_q[FLG_CMPB] <= 1'b1;
      end else if (wr_flags && w_strb_q[0] && w_data_q[FLG_CMPB]) begin
        flags_q[FLG_CMPB] <= 1'b0;
      end
      if (top_is_cap && at_top) begin
        flags_q[FLG_CAP] <= 1'b1;
      end else if (wr_flags && w_strb_q[0] && w_data_q[FLG_CAP]) begin
        flags_q[FLG_CAP] <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // per channel: compare registers, match and waveform

  for (genvar i = 0; i < 2; i++) begin : g_chan
    // compare value above top can never match
    assign match[i] = tick && !block_q && (count_q == cmp_q[i]) && (cmp_q[i] <= top);
    assign wval_cmp[i] = merge16(cmp_buf_q[i], w_data_q, w_strb_q) & wmask;

    // buffered in fast PWM, written straight through otherwise
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        cmp_q[i]     <= CNT_BOTTOM;
        cmp_buf_q[i] <= CNT_BOTTOM;
      end else begin
        if (wr_cmp[i]) begin
          cmp_buf_q[i] <= wval_cmp[i];
        end
        if (wr_cmp[i] && !is_fpwm) begin
          cmp_q[i] <= wval_cmp[i];
        end else if (is_fpwm && at_top) begin
          cmp_q[i] <= cmp_buf_q[i];
        end
      end
    end

    // in fast PWM clear and set, bottom wins over a match at top, so compare equal to top is constant
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        wave_q[i] <= 1'b0;
      end else if (act[i] == ACT_NONE) begin
        wave_q[i] <= wave_q[i];
      end else if (is_fpwm) begin
        unique case (act[i])
          ACT_CLEAR: begin
            if (at_top) begin
              wave_q[i] <= 1'b1;
            end else if (match[i]) begin
              wave_q[i] <= 1'b0;
            end
          end
          ACT_SET: begin
            if (at_top) begin
              wave_q[i] <= 1'b0;
            end else if (match[i]) begin
              wave_q[i] <= 1'b1;
            end
          end
          default: begin
            // toggle is offered on channel A only in fast PWM
            if (i == 0 && match[i]) begin
              wave_q[i] <= !wave_q[i];
            end
          end
        endcase
      end else if (match[i]) begin
        unique case (act[i])
          ACT_TOGGLE: wave_q[i] <= !wave_q[i];
          ACT_CLEAR:  wave_q[i] <= 1'b0;
          default:    wave_q[i] <= 1'b1;
        endcase
      end
    end

    // pin shows the waveform only when an action is selected
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        pin_o_q[i]  <= 1'b0;
        pin_oe_q[i] <= 1'b0;
      end else begin
        pin_o_q[i]  <= (act[i] != ACT_NONE) && wave_q[i];
        pin_oe_q[i] <= pindir_q[i];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register writes

  assign wr_do     = aw_have_q && w_have_q && !bvalid_q;
  assign wr_ctrl   = wr_do && hit(aw_addr_q, ADDR_CTRL);
  assign wr_count  = wr_do && hit(aw_addr_q, ADDR_COUNT);
  assign wr_cmp[0] = wr_do && hit(aw_addr_q, ADDR_CMPA);
  assign wr_cmp[1] = wr_do && hit(aw_addr_q, ADDR_CMPB);
  assign wr_captop = wr_do && hit(aw_addr_q, ADDR_CAPTOP);
  assign wr_flags  = wr_do && hit(aw_addr_q, ADDR_FLAGS);
  assign wr_pindir = wr_do && hit(aw_addr_q, ADDR_PINDIR);

  assign wval_ctrl   = merge16(ctrl_q, w_data_q, w_strb_q);
  assign wval_count  = merge16(count_q, w_data_q, w_strb_q);
  assign wval_captop = merge16(captop_q, w_data_q, w_strb_q);

  // plain configuration registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q   <= CTRL_RST;
      captop_q <= CNT_BOTTOM;
      pindir_q <= 2'h0;
    end else begin
      if (wr_ctrl) begin
        ctrl_q <= wval_ctrl;
      end
      if (wr_captop) begin
        captop_q <= wval_captop;
      end
      if (wr_pindir && w_strb_q[0]) begin
        pindir_q <= w_data_q[1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write channels: address and data in either order

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_q <= 1'b0;
      aw_have_q <= 1'b0;
      aw_addr_q <= 8'h00;
    end else if (s_axi_awvalid && awready_q) begin
      awready_q <= 1'b0;
      aw_have_q <= 1'b1;
      aw_addr_q <= s_axi_awaddr;
    end else if (wr_do) begin
      aw_have_q <= 1'b0;
    end else if (!aw_have_q && !bvalid_q) begin
      awready_q <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wready_q <= 1'b0;
      w_have_q <= 1'b0;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
    end else if (s_axi_wvalid && wready_q) begin
      wready_q <= 1'b0;
      w_have_q <= 1'b1;
      w_data_q <= s_axi_wdata;
      w_strb_q <= s_axi_wstrb;
    end else if (wr_do) begin
      w_have_q <= 1'b0;
    end else if (!w_have_q && !bvalid_q) begin
      wready_q <= 1'b1;
    end
  end

  // response after both halves; unmapped addresses answer slave error
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q  <= RESP_OKAY;
    end else if (wr_do) begin
      bvalid_q <= 1'b1;
      bresp_q  <= (wr_ctrl || wr_count || wr_cmp[0] || wr_cmp[1] || wr_captop || wr_flags || wr_pindir)
                  ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready && bvalid_q) begin
      bvalid_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read channel

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h0000_0000;
      rresp_q   <= RESP_OKAY;
    end else if (s_axi_arvalid && arready_q) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b1;
      rresp_q   <= RESP_OKAY;
      // buffers are not readable; compare reads return the active value
      if (hit(s_axi_araddr, ADDR_CTRL)) begin
        rdata_q <= {16'h0000, ctrl_q};
      end else if (hit(s_axi_araddr, ADDR_COUNT)) begin
        rdata_q <= {16'h0000, count_q};
      end else if (hit(s_axi_araddr, ADDR_CMPA)) begin
        rdata_q <= {16'h0000, cmp_q[0]};
      end else if (hit(s_axi_araddr, ADDR_CMPB)) begin
        rdata_q <= {16'h0000, cmp_q[1]};
      end else if (hit(s_axi_araddr, ADDR_CAPTOP)) begin
        rdata_q <= {16'h0000, captop_q};
      end else if (hit(s_axi_araddr, ADDR_FLAGS)) begin
        rdata_q <= {28'h000_0000, flags_q};
      end else if (hit(s_axi_araddr, ADDR_PINDIR)) begin
        rdata_q <= {30'h0000_0000, pindir_q};
      end else begin
        rdata_q <= 32'h0000_0000;
        rresp_q <= RESP_SLVERR;
      end
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_q <= 1'b0;
    end else if (!rvalid_q) begin
      arready_q <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign s_axi_awready   = awready_q;
  assign s_axi_wready    = wready_q;
  assign s_axi_bvalid    = bvalid_q;
  assign s_axi_bresp     = bresp_q;
  assign s_axi_arready   = arready_q;
  assign s_axi_rvalid    = rvalid_q;
  assign s_axi_rdata     = rdata_q;
  assign s_axi_rresp     = rresp_q;
  assign waveform_pin_o  = pin_o_q;
  assign waveform_pin_oe = pin_oe_q;

endmodule

// [rtl/tcwm_pkg.sv]
package tcwm_pkg;
  // register byte addresses
  localparam logic [7:0]  ADDR_CTRL    = 8'h00;
  localparam logic [7:0]  ADDR_COUNT   = 8'h04;
  localparam logic [7:0]  ADDR_CMPA    = 8'h08;
  localparam logic [7:0]  ADDR_CMPB    = 8'h0C;
  localparam logic [7:0]  ADDR_CAPTOP  = 8'h10;
  localparam logic [7:0]  ADDR_FLAGS   = 8'h14;
  localparam logic [7:0]  ADDR_PINDIR  = 8'h18;
  // control field positions
  localparam int          CTRL_MODE_LSB = 0;
  localparam int          CTRL_ACTA_LSB = 4;
  localparam int          CTRL_ACTB_LSB = 6;
  localparam int          CTRL_PSC_LSB  = 8;
  localparam logic [15:0] CTRL_RST      = 16'h0000;
  // flag bit positions
  localparam int          FLG_OVF  = 0;
  localparam int          FLG_CMPA = 1;
  localparam int          FLG_CMPB = 2;
  localparam int          FLG_CAP  = 3;
  // waveform modes handled here
  localparam logic [3:0]  MODE_NORMAL   = 4'h0;
  localparam logic [3:0]  MODE_CTC_CMPA = 4'h4;
  localparam logic [3:0]  MODE_FPWM8    = 4'h5;
  localparam logic [3:0]  MODE_FPWM9    = 4'h6;
  localparam logic [3:0]  MODE_FPWM10   = 4'h7;
  localparam logic [3:0]  MODE_CTC_CAP  = 4'hC;
  localparam logic [3:0]  MODE_FPWM_CAP = 4'hE;
  localparam logic [3:0]  MODE_FPWM_CMP = 4'hF;
  // counter values
  localparam logic [15:0] CNT_BOTTOM = 16'h0000;
  localparam logic [15:0] CNT_MAX    = 16'hFFFF;
  localparam logic [15:0] TOP_8BIT   = 16'h00FF;
  localparam logic [15:0] TOP_9BIT   = 16'h01FF;
  localparam logic [15:0] TOP_10BIT  = 16'h03FF;
  // output actions
  localparam logic [1:0]  ACT_NONE   = 2'h0;
  localparam logic [1:0]  ACT_TOGGLE = 2'h1;
  localparam logic [1:0]  ACT_CLEAR  = 2'h2;
  localparam logic [1:0]  ACT_SET    = 2'h3;
  // prescaler select codes and divisors
  localparam logic [2:0]  PSC_STOP  = 3'h0;
  localparam logic [2:0]  PSC_1     = 3'h1;
  localparam logic [2:0]  PSC_8     = 3'h2;
  localparam logic [2:0]  PSC_64    = 3'h3;
  localparam logic [2:0]  PSC_256   = 3'h4;
  localparam logic [10:0] DIV_1     = 11'h001;
  localparam logic [10:0] DIV_8     = 11'h008;
  localparam logic [10:0] DIV_64    = 11'h040;
  localparam logic [10:0] DIV_256   = 11'h100;
  localparam logic [10:0] DIV_1024  = 11'h400;
  // bus responses
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;
endpackage

// [verif/tcwm_checker.sv]
`timescale 1ns/1ps
////////////////////////////////////////////////////////////
// bus handshake timing and pin reset state, seen at the block's ports
module tcwm_checker (
  input wire logic       aclk,
  input wire logic       aresetn,
  input wire logic       s_axi_awvalid,
  input wire logic       s_axi_awready,
  input wire logic       s_axi_wvalid,
  input wire logic       s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic       s_axi_bvalid,
  input wire logic       s_axi_bready,
  input wire logic       s_axi_arvalid,
  input wire logic       s_axi_arready,
  input wire logic [1:0] s_axi_rresp,
  input wire logic       s_axi_rvalid,
  input wire logic       s_axi_rready,
  input wire logic [1:0] waveform_pin_o,
  input wire logic [1:0] waveform_pin_oe
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // both write channels taken at one edge
  sequence wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  // reset must be watched while it is asserted, so no disable here
  reset_pins_a: assert property (disable iff (1'b0) !aresetn |=> waveform_pin_o == 2'h0 && waveform_pin_oe == 2'h0)
    else $error("pins not cleared by reset");
  wr_answer_a: assert property (wr_take |=> !s_axi_bvalid ##1 s_axi_bvalid)
    else $error("write response late or early");
  wr_ready_drop_a: assert property (wr_take |=> !s_axi_awready && !s_axi_wready)
    else $error("write ready stayed high after take");
  b_release_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid ##1 (s_axi_awready && s_axi_wready))
    else $error("write channel not freed after response");
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read data not one cycle after address");
  r_release_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid ##1 s_axi_arready)
    else $error("read channel not freed after data");
  b_resp_legal_a: assert property (s_axi_bvalid |-> s_axi_bresp inside {2'h0, 2'h2})
    else $error("write response code illegal");
  r_resp_legal_a: assert property (s_axi_rvalid |-> s_axi_rresp inside {2'h0, 2'h2})
    else $error("read response code illegal");
endmodule
bind tcwm_counter16 tcwm_checker chk (.*);

// [verif/tcwm_counter16_test.sv]
`timescale 1ns/1ps
module tcwm_counter16_test;
  import tcwm_pkg::*;
  logic        aclk = 1'b0, aresetn = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, waveform_pin_o, waveform_pin_oe;
  logic [15:0] rv;                        // last read data
  logic [1:0]  rr, br;                    // last read and write responses
  int          miscompares = 0, compares = 0, hi, lo;
  tcwm_counter16 dut (.*);
  always #25 aclk = ~aclk;                // 20 MHz
  ////////////////////////////////////////////////////////////
  task automatic close_out();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  // a wait that used up its bound ends the run
  task automatic bound(input int n);
    if (n >= 3000) begin
      miscompares++;
      close_out();
    end
  endtask
  // write: address and data offered together, each dropped when taken
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    int n;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {16'h0000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 3000 && !(s_axi_bvalid && s_axi_bready); n++) begin
      @(posedge aclk);
      if (s_axi_awready && s_axi_awvalid) s_axi_awvalid <= 1'b0;
      if (s_axi_wready && s_axi_wvalid) s_axi_wvalid <= 1'b0;
    end
    br = s_axi_bresp;
    s_axi_bready <= 1'b0;
    bound(n);
  endtask
  task automatic rd(input logic [7:0] a);
    int n;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 3000 && !(s_axi_rvalid && s_axi_rready); n++) begin
      @(posedge aclk);
      if (s_axi_arready && s_axi_arvalid) s_axi_arvalid <= 1'b0;
    end
    rv = s_axi_rdata[15:0];
    rr = s_axi_rresp;
    s_axi_rready <= 1'b0;
    bound(n);
  endtask
  // one whole high and low phase of channel A, skipping any partial one
  task automatic span();
    int n;
    for (n = 0; n < 3000 && waveform_pin_o[0] !== 1'b0; n++) @(posedge aclk);
    for (; n < 3000 && waveform_pin_o[0] !== 1'b1; n++) @(posedge aclk);
    for (hi = 0; hi < 3000 && waveform_pin_o[0] === 1'b1; hi++) @(posedge aclk);
    for (lo = 0; lo < 3000 && waveform_pin_o[0] === 1'b0; lo++) @(posedge aclk);
    bound(n + hi + lo);
  endtask
  ////////////////////////////////////////////////////////////
  task automatic t_reset();
    logic [7:0] regs [7] = '{ADDR_CTRL, ADDR_COUNT, ADDR_CMPA, ADDR_CMPB, ADDR_CAPTOP, ADDR_FLAGS, ADDR_PINDIR};
    wr(8'h1C, 16'hFFFF);                  // unmapped write must change nothing
    chk(br, RESP_SLVERR);
    foreach (regs[i]) begin
      rd(regs[i]);
      chk(rv, 32'h0);
    end
    rd(8'h1C);                            // unmapped
    chk(rr, RESP_SLVERR);
  endtask
  // start just below the wrap so overflow shows quickly
  task automatic t_normal();
    wr(ADDR_COUNT, 16'hFFF0);
    wr(ADDR_CTRL, 16'h0100);
    repeat (40) @(posedge aclk);
    wr(ADDR_CTRL, 16'h0000);
    rd(ADDR_FLAGS);
    chk(rv[0], 1'b1);
    rd(ADDR_COUNT);
    chk(rv < 16'h0040, 1'b1);
    wr(ADDR_FLAGS, 16'h0001);
    rd(ADDR_FLAGS);
    chk(rv[0], 1'b0);
  endtask
  // a leftover count above the new top would first run to the wrap
  task automatic t_ctc();
    wr(ADDR_COUNT, 16'h0000);
    wr(ADDR_FLAGS, 16'h000F);
    wr(ADDR_CMPA, 16'h0003);
    wr(ADDR_PINDIR, 16'h0001);
    chk(br, RESP_OKAY);
    @(posedge aclk);                      // pin enable lags the register by one edge
    chk(waveform_pin_oe, 2'h1);
    wr(ADDR_CTRL, 16'h0114);
    span();
    chk(hi + lo, 8);
    chk(hi, 4);
    wr(ADDR_CTRL, 16'h0014);
    rd(ADDR_COUNT);
    chk(rv <= 16'h0003, 1'b1);
    rd(ADDR_FLAGS);
    chk(rv[1:0], 2'h2);
  endtask
  // compare written above the 8-bit top, so the high bits must drop
  task automatic t_fpwm(input logic [1:0] act);
    wr(ADDR_CTRL, {5'h00, PSC_STOP, 2'h0, act, MODE_FPWM8});
    wr(ADDR_CMPA, 16'h0164);
    wr(ADDR_CTRL, {5'h00, PSC_1, 2'h0, act, MODE_FPWM8});
    span();
    chk(hi + lo, 256);
    chk(hi, act == ACT_CLEAR ? 101 : 155);
    chk(waveform_pin_o[1], 1'b0);
    rd(ADDR_CMPA);
    chk(rv, 16'h0064);
  endtask
  // compare A as buffered top, toggling A; the old top 0x64 runs out first
  task automatic t_fpwm_var();
    wr(ADDR_CTRL, {5'h00, PSC_STOP, 2'h0, ACT_TOGGLE, MODE_FPWM_CMP});
    wr(ADDR_COUNT, 16'h0000);
    wr(ADDR_FLAGS, 16'h000F);
    wr(ADDR_CMPA, 16'h0003);
    wr(ADDR_CTRL, {5'h00, PSC_1, 2'h0, ACT_TOGGLE, MODE_FPWM_CMP});
    span();
    chk(hi, 4);
    chk(lo, 4);
    wr(ADDR_CTRL, {5'h00, PSC_STOP, 2'h0, ACT_TOGGLE, MODE_FPWM_CMP});
    rd(ADDR_FLAGS);
    chk(rv[3:0], 4'h7);
  endtask
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_normal();
    t_ctc();
    t_fpwm(ACT_CLEAR);
    t_fpwm(ACT_SET);
    t_fpwm_var();
    close_out();
  end
endmodule
